// file: pkg/epm_pkg.sv
// Shared constants and types for the power-mode controller and its host end.
// Assumes a single 40 MHz clock shared by both ends.
package epm_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ            = 40;
  localparam int CS_PULSE_NS        = 200;
  localparam int CS_PULSE_CYC       = (CS_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_ARM_US        = 1000;
  localparam int WAKE_ARM_CYC       = WAKE_ARM_US * CLK_MHZ;
  localparam int PD_WAKE_CYC        = 400;
  localparam int SLEEP_WAKE_CYC     = 40;
  localparam int SHUTDOWN_CYC       = 200;
  localparam int PROG_FULL_CYC      = 800;
  localparam int PROG_HALF_CYC      = 400;
  localparam int MEASURE_CYC        = 64;
  localparam int CNT_W              = 16;
  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_STANDBY  = 8'hE0;
  localparam logic [7:0] OP_SLEEP    = 8'hE1;
  localparam logic [7:0] OP_PDOWN    = 8'hE2;
  localparam logic [7:0] OP_WEAR     = 8'hE8;
  localparam logic [7:0] OP_FETCH    = 8'hF9;
  localparam logic [7:0] OP_STATUS   = 8'h05;
  localparam logic [7:0] OP_SUPPLY   = 8'hEA;
  localparam logic [7:0] OP_WRITE    = 8'h02;
  localparam logic [7:0] OP_READ     = 8'h03;
  // ------------------------------------------------------------
  // Result layouts
  // ------------------------------------------------------------
  localparam int WEAR_LSB   = 24;
  localparam int WEAR_MSB   = 31;
  localparam int LEVEL_LSB  = 4;
  localparam int LEVEL_MSB  = 7;
  localparam int NSECT      = 8;
  localparam int PAGE_BYTES = 128;
  localparam int SECT_BYTES = 256;
  localparam int WORD_BYTES = 4;
  localparam int ADDR_W     = 19;
  localparam int PAGE_LSB   = 7;
  localparam int SECT_LSB   = 8;
  localparam int WEAR_LIMIT = 16;
  localparam int RDY_BIT    = 24;
  // ------------------------------------------------------------
  // Host register map (APB)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_PINS   = 8'h10;
  localparam int PIN_WAKE   = 0;
  localparam int ST_BUSY    = 0;
  localparam int ST_VALID   = 1;
  // ------------------------------------------------------------
  // Power modes
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    PM_PDOWN   = 7'b0000001,
    PM_RAMP    = 7'b0000010,
    PM_STANDBY = 7'b0000100,
    PM_SLEEP   = 7'b0001000,
    PM_WAKESLP = 7'b0010000,
    PM_PROG    = 7'b0100000,
    PM_SHUT    = 7'b1000000
  } epm_mode_t;
endpackage

// file: pkg/epm_if.sv
// Command link between host controller and power-mode controller.
// Chip-select, wake pin, a byte-wide command opcode path and a 32-bit response path.
`timescale 1ns/1ps
interface epm_if;
  logic        cs_b;
  logic        wake;
  logic        cmd_valid;
  logic [7:0]  cmd_op;
  logic [18:0] cmd_addr;
  logic [7:0]  cmd_len;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  modport dev  (input cs_b, wake, cmd_valid, cmd_op, cmd_addr, cmd_len,
                output rsp_valid, rsp_data);
  modport host (output cs_b, wake, cmd_valid, cmd_op, cmd_addr, cmd_len,
                input rsp_valid, rsp_data);
endinterface

// file: verilog/epm_device.sv
// Power-mode controller of the serial memory: modes, wake, prepared reads.
// Assumes cs_b and wake are pins; commands arrive with cs_b high (framed).
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module epm_device
  import epm_pkg::*;
#(
  parameter int ARM_CYC = WAKE_ARM_CYC
)(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Link
  epm_if.dev              lnk,
  // Board side
  input  wire logic [3:0] supply_level,
  input  wire logic [7:0] sector_enable,
  output logic            array_on,
  output logic [7:0]      sector_on,
  output logic            aux_on,
  output logic            ready_b,
  output logic            mode_sleep
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic cs_m, cs_s, wk_m, wk_s, cs_d;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      wk_m <= 1'b0;
      wk_s <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      cs_m <= lnk.cs_b;
      cs_s <= cs_m;
      wk_m <= lnk.wake;
      wk_s <= wk_m;
      cs_d <= cs_s;
    end
  end
  wire cs_rise = cs_s & ~cs_d;
  // ------------------------------------------------------------
  // Power-on arm counter and boot strap
  // ------------------------------------------------------------
  logic [CNT_W+1:0] arm_cnt;
  logic             armed;
  logic [1:0]       boot_cnt;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arm_cnt <= '0;
      armed   <= 1'b0;
    end else if (!armed) begin
      arm_cnt <= arm_cnt + 1'b1;
      armed   <= (arm_cnt >= (CNT_W+2)'(ARM_CYC - 1));
    end
  end
  // ------------------------------------------------------------
  // Mode machine
  // ------------------------------------------------------------
  epm_mode_t        mode;
  logic [CNT_W-1:0] tmr;
  logic             meas_busy;
  logic [CNT_W-1:0] meas_tmr;
  logic             prog_pend;
  logic [8:0]       prog_len;
  logic             cs_seen;
  logic             wake_used;
  wire cmd = lnk.cmd_valid;
  wire [7:0] op = lnk.cmd_op;
  wire idle = (mode == PM_STANDBY) & ~meas_busy;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode      <= PM_RAMP;
      tmr       <= CNT_W'(PD_WAKE_CYC);
      boot_cnt  <= 2'h0;
      prog_pend <= 1'b0;
      prog_len  <= '0;
      cs_seen   <= 1'b0;
      wake_used <= 1'b0;
    end else begin
      if (boot_cnt != 2'h3) begin
        // Wait for the wake synchroniser to fill before sampling it
        boot_cnt <= boot_cnt + 2'h1;
        if (boot_cnt == 2'h2) begin
          mode <= wk_s ? PM_RAMP : PM_PDOWN;
        end
      end else begin
        case (mode)
          PM_PDOWN: begin
            if (wk_s && !wake_used) begin
              mode      <= PM_RAMP;
              tmr       <= CNT_W'(PD_WAKE_CYC);
              wake_used <= 1'b1;
            end else if (!cs_s && armed) begin
              cs_seen <= 1'b1;
            end else if (cs_seen && cs_s) begin
              cs_seen <= 1'b0;
              mode    <= PM_RAMP;
              tmr     <= CNT_W'(PD_WAKE_CYC);
            end
            if (!wk_s) begin
              wake_used <= 1'b0;
            end
          end
          PM_RAMP: begin
            // Held chip-select stalls the ramp
            if (cs_s) begin
              if (tmr == '0) begin
                mode <= PM_STANDBY;
              end else begin
                tmr <= tmr - 1'b1;
              end
            end
          end
          PM_STANDBY: begin
            if (prog_pend && cs_rise) begin
              prog_pend <= 1'b0;
              mode      <= PM_PROG;
              tmr       <= (prog_len >= 9'(SECT_BYTES)) ? CNT_W'(PROG_FULL_CYC)
                                                        : CNT_W'(PROG_HALF_CYC);
            end else if (cmd && op == OP_WRITE && !meas_busy) begin
              prog_pend <= 1'b1;
              prog_len  <= {1'b0, lnk.cmd_len} + 9'd1;
            end else if (cmd && op == OP_SLEEP && !meas_busy) begin
              mode <= PM_SLEEP;
            end else if (cmd && op == OP_PDOWN && !meas_busy) begin
              mode <= PM_SHUT;
              tmr  <= CNT_W'(SHUTDOWN_CYC);
            end
          end
          PM_SLEEP: begin
            if (cmd && op == OP_STANDBY) begin
              mode <= PM_WAKESLP;
              tmr  <= CNT_W'(SLEEP_WAKE_CYC);
            end else if (cmd && op == OP_PDOWN) begin
              mode <= PM_SHUT;
              tmr  <= CNT_W'(SHUTDOWN_CYC);
            end
          end
          PM_WAKESLP: begin
            if (tmr == '0) begin
              mode <= PM_STANDBY;
            end else begin
              tmr <= tmr - 1'b1;
            end
          end
          PM_PROG: begin
            // Power-down and sleep are dropped here
            if (tmr == '0) begin
              mode <= PM_STANDBY;
            end else begin
              tmr <= tmr - 1'b1;
            end
          end
          PM_SHUT: begin
            if (tmr == '0) begin
              mode    <= PM_PDOWN;
              cs_seen <= 1'b0;
            end else begin
              tmr <= tmr - 1'b1;
            end
          end
          default: mode <= PM_PDOWN;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Wear tracking per page, reported per sector
  // ------------------------------------------------------------
  logic [7:0] page_wear [0:(1<<(ADDR_W-PAGE_LSB))-1];
  logic [NSECT-1:0] worn;
  wire [ADDR_W-PAGE_LSB-1:0] pg = lnk.cmd_addr[ADDR_W-1:PAGE_LSB];
  wire [2:0] sect = lnk.cmd_addr[ADDR_W-1:ADDR_W-3];
  // One count per write; reset so no count starts unknown
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      worn <= '0;
      for (int i = 0; i < (1 << (ADDR_W - PAGE_LSB)); i++) begin
        page_wear[i] <= 8'h00;
      end
    end else if (idle && cmd && op == OP_WRITE) begin
      if (page_wear[pg] != 8'hFF) begin
        page_wear[pg] <= page_wear[pg] + 8'h01;
      end
      if (page_wear[pg] >= 8'(WEAR_LIMIT - 1)) begin
        worn[sect] <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // Prepared reads and response
  // ------------------------------------------------------------
  logic [31:0] prepared;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prepared      <= '0;
      meas_busy     <= 1'b0;
      meas_tmr      <= '0;
      lnk.rsp_valid <= 1'b0;
      lnk.rsp_data  <= '0;
    end else begin
      lnk.rsp_valid <= 1'b0;
      if (meas_busy) begin
        if (meas_tmr == '0) begin
          meas_busy <= 1'b0;
          prepared  <= {24'h000000, supply_level, 4'h0};
        end else begin
          meas_tmr <= meas_tmr - 1'b1;
        end
      end
      if (cmd && op == OP_STATUS && mode != PM_PDOWN) begin
        lnk.rsp_valid <= 1'b1;
        lnk.rsp_data  <= {7'h00, ~idle, 24'h000000};
      end else if (cmd && idle) begin
        if (op == OP_WEAR) begin
          prepared <= {worn, 24'h000000};
        end else if (op == OP_SUPPLY) begin
          meas_busy <= 1'b1;
          meas_tmr  <= CNT_W'(MEASURE_CYC);
        end else if (op == OP_FETCH) begin
          lnk.rsp_valid <= 1'b1;
          lnk.rsp_data  <= prepared;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      array_on   <= 1'b0;
      sector_on  <= '0;
      aux_on     <= 1'b0;
      ready_b    <= 1'b1;
      mode_sleep <= 1'b0;
    end else begin
      array_on   <= (mode == PM_STANDBY) | (mode == PM_PROG);
      sector_on  <= ((mode == PM_STANDBY) | (mode == PM_PROG)) ? sector_enable : '0;
      aux_on     <= (mode == PM_STANDBY) | (mode == PM_PROG);
      ready_b    <= ~idle;
      mode_sleep <= (mode == PM_SLEEP);
    end
  end
endmodule

// file: verilog/epm_host.sv
// Host end: APB-controlled command issuer for the power-mode controller.
// Assumes same clock as device; software sequences polls via registers.
`timescale 1ns/1ps
module epm_host
  import epm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  epm_if.host              lnk
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [18:0]      addr_r;
  logic [7:0]       len_r;
  logic [31:0]      result;
  logic             valid;
  logic             busy;
  logic [CNT_W-1:0] cs_cnt;
  logic             pulse;
  wire acc = psel & penable;
  wire wr  = acc & pwrite;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr inside {REG_CMD, REG_ADDR, REG_STAT,
                                                  REG_RESULT, REG_PINS});
      case (paddr)
        REG_ADDR:   prdata <= {5'h00, len_r, addr_r};
        REG_STAT:   prdata <= {30'h0, valid, busy};
        REG_RESULT: prdata <= result;
        REG_PINS:   prdata <= {31'h0, lnk.wake};
        default:    prdata <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command issue; polling is software's loop on REG_STAT/RESULT
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r        <= '0;
      len_r         <= '0;
      result        <= '0;
      valid         <= 1'b0;
      busy          <= 1'b0;
      cs_cnt        <= '0;
      pulse         <= 1'b0;
      lnk.cs_b      <= 1'b1;
      lnk.wake      <= 1'b0;
      lnk.cmd_valid <= 1'b0;
      lnk.cmd_op    <= '0;
      lnk.cmd_addr  <= '0;
      lnk.cmd_len   <= '0;
    end else begin
      lnk.cmd_valid <= 1'b0;
      if (lnk.rsp_valid) begin
        result <= lnk.rsp_data;
        valid  <= 1'b1;
      end
      if (pulse) begin
        if (cs_cnt == '0) begin
          pulse    <= 1'b0;
          lnk.cs_b <= 1'b1;
        end else begin
          cs_cnt <= cs_cnt - 1'b1;
        end
      end
      busy <= pulse;
      if (wr && pready && paddr == REG_ADDR) begin
        addr_r <= pwdata[18:0];
        len_r  <= pwdata[26:19];
      end
      if (wr && pready && paddr == REG_PINS) begin
        lnk.wake <= pwdata[PIN_WAKE];
      end
      if (wr && pready && paddr == REG_CMD && !pulse) begin
        if (pwdata[8]) begin
          pulse    <= 1'b1;
          lnk.cs_b <= 1'b0;
          cs_cnt   <= CNT_W'(CS_PULSE_CYC);
        end else begin
          lnk.cmd_valid <= 1'b1;
          lnk.cmd_op    <= pwdata[7:0];
          lnk.cmd_addr  <= addr_r;
          lnk.cmd_len   <= len_r;
          if (pwdata[7:0] != OP_WRITE) begin
            valid <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// file: verification/epm_link_properties.sv
// Concurrent checks on the host-device command link.
// Assumes one clock domain; takes the link signals of the interface as inputs.
`timescale 1ns/1ps
module epm_link_properties
  import epm_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Link
  input wire logic        cs_b,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_op,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Query tracking assumes queries are only sent while the device can take them
  logic [7:0] last_query;
  logic [7:0] meas_cnt;
  logic       in_sleep;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) last_query <= 8'h00;
    else if (cmd_valid && (cmd_op == OP_WEAR || cmd_op == OP_SUPPLY)) last_query <= cmd_op;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) meas_cnt <= 8'hFF;
    else if (cmd_valid && cmd_op == OP_SUPPLY) meas_cnt <= 8'h00;
    else if (meas_cnt != 8'hFF) meas_cnt <= meas_cnt + 8'h01;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) in_sleep <= 1'b0;
    else if (cmd_valid && cmd_op == OP_SLEEP) in_sleep <= 1'b1;
    else if (cmd_valid && (cmd_op == OP_STANDBY || cmd_op == OP_PDOWN)) in_sleep <= 1'b0;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  resp_cause_a: assert property (rsp_valid |-> $past(cmd_valid) &&
    ($past(cmd_op) == OP_STATUS || $past(cmd_op) == OP_FETCH))
    else $error("response without status or fetch request");
  wear_layout_a: assert property (rsp_valid && $past(cmd_op) == OP_FETCH &&
    last_query == OP_WEAR |-> rsp_data[23:0] == 24'h000000)
    else $error("wear word low bits not clear");
  supply_layout_a: assert property (rsp_valid && $past(cmd_op) == OP_FETCH &&
    last_query == OP_SUPPLY |-> rsp_data[31:8] == 24'h000000 && rsp_data[3:0] == 4'h0)
    else $error("supply word outside level field not clear");
  meas_busy_a: assert property (rsp_valid && $past(cmd_op) == OP_STATUS &&
    meas_cnt < 8'd48 |-> rsp_data[RDY_BIT])
    else $error("ready shown during measurement");
  sleep_filter_a: assert property (rsp_valid && in_sleep |->
    $past(cmd_op) == OP_STATUS)
    else $error("response to a command refused in sleep");
  cs_min_a: assert property ($fell(cs_b) |-> (!cs_b) [*8])
    else $error("chip-select pulse shorter than 200 ns");
  cs_end_a: assert property ($fell(cs_b) |-> ##[8:20] cs_b)
    else $error("chip-select not released");
  reset_idle_a: assert property ($rose(rst_b) |-> cs_b && !cmd_valid)
    else $error("host busy on the link at boot");
  fetch_c: cover property (rsp_valid && $past(cmd_op) == OP_FETCH);
  pulse_c: cover property ($rose(cs_b));
  sleep_stat_c: cover property (rsp_valid && in_sleep);
endmodule

// file: verification/eeprom_power_mode_control_bench.sv
// Bench for the power-mode controller driven through its host end over APB.
// Assumes both ends share mclk; the wake arm count is shortened for simulation.
`timescale 1ns/1ps
module eeprom_power_mode_control_bench;
  import epm_pkg::*;
  // ----------------------------------------
  // Signals and ends
  // ----------------------------------------
  localparam int ARM_SIM = 50;
  localparam int TIMEOUT = 40000;
  logic        mclk;
  logic        rst_b;
  logic        dev_rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  supply_level;
  logic [7:0]  sector_enable;
  logic        array_on;
  logic [7:0]  sector_on;
  logic        aux_on;
  logic        ready_b;
  logic        mode_sleep;
  logic [31:0] q;
  logic        err;
  int          n;
  int          polls;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  epm_if epm_if_inst ();
  epm_device #(.ARM_CYC(ARM_SIM)) epm_device_inst (.mclk(mclk), .rst_b(dev_rst_b),
    .lnk(epm_if_inst), .supply_level(supply_level), .sector_enable(sector_enable),
    .array_on(array_on), .sector_on(sector_on), .aux_on(aux_on), .ready_b(ready_b),
    .mode_sleep(mode_sleep));
  epm_host epm_host_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(epm_if_inst));
  epm_link_properties epm_link_properties_inst (.mclk(mclk), .rst_b(rst_b),
    .cs_b(epm_if_inst.cs_b), .cmd_valid(epm_if_inst.cmd_valid), .cmd_op(epm_if_inst.cmd_op),
    .rsp_valid(epm_if_inst.rsp_valid), .rsp_data(epm_if_inst.rsp_data));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) n_mismatch++;
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op);
    apb(1'b1, REG_CMD, {24'h000000, op});
  endtask
  // Gap lets the link response land in the result register first
  task automatic rd(input logic [7:0] a);
    repeat (2) @(posedge mclk);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic pulse();
    apb(1'b1, REG_CMD, 32'h00000100);
  endtask
  task automatic wait_rdy();
    n = 0;
    while (ready_b !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic wait_busy();
    for (int k = 0; k < 60 && ready_b !== 1'b1; k++) @(posedge mclk);
  endtask
  task automatic wear_word();
    cmd(OP_WEAR);
    cmd(OP_FETCH);
    rd(REG_RESULT);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    dev_rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    supply_level = 4'h0;
    sector_enable = 8'h5A;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    dev_rst_b <= 1'b1;
    pulse();
    repeat (500) @(posedge mclk);
    chk(ready_b, 1'b1, "pd before arm");
    apb(1'b1, REG_PINS, 32'h00000001);
    wait_rdy();
    chk(n >= PD_WAKE_CYC - 8 && n <= PD_WAKE_CYC + 8, 1'b1, "wake pin ramp");
    chk(sector_on, sector_enable, "standby sectors");
    chk({array_on, aux_on}, 2'b11, "standby rails");
    // Device-only reset with wake still high: boot goes to standby
    dev_rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    dev_rst_b <= 1'b1;
    wait_rdy();
    chk(n >= PD_WAKE_CYC - 8 && n <= PD_WAKE_CYC + 8, 1'b1, "boot standby");
    apb(1'b1, REG_PINS, 32'h00000000);
    wear_word();
    chk(q, 32'h00000000, "wear clean");
    for (int i = 0; i < 2; i++) begin
      supply_level <= (i == 0) ? 4'h0 : 4'hF;
      cmd(OP_SUPPLY);
      polls = 0;
      do begin
        cmd(OP_STATUS);
        rd(REG_RESULT);
        polls++;
      end while (q[RDY_BIT] !== 1'b0 && polls < 40);
      chk(polls > 1, 1'b1, "busy polls");
      cmd(OP_FETCH);
      rd(REG_RESULT);
      chk(q, {24'h000000, supply_level, 4'h0}, "supply word");
    end
    // Different words of one page: wear must add up per page
    for (int i = 0; i < WEAR_LIMIT; i++) begin
      apb(1'b1, REG_ADDR, 32'h00030300 + 4 * i);
      cmd(OP_WRITE);
      repeat (20) @(posedge mclk);
      chk(ready_b, 1'b0, "prog waits cs");
      pulse();
      wait_busy();
      wait_rdy();
      chk(n >= PROG_HALF_CYC - 5 && n <= PROG_HALF_CYC + 5, 1'b1, "half prog");
      if (i == WEAR_LIMIT - 2) begin
        wear_word();
        chk(q, 32'h00000000, "below limit");
      end
    end
    wear_word();
    chk(q, 32'h1 << (WEAR_LSB + 3), "sector 3 worn");
    apb(1'b1, REG_ADDR, {5'h00, 8'hFF, 19'h00500});
    cmd(OP_WRITE);
    pulse();
    wait_busy();
    cmd(OP_SLEEP);
    cmd(OP_PDOWN);
    wait_rdy();
    chk(n >= PROG_FULL_CYC - 30 && n <= PROG_FULL_CYC + 5, 1'b1, "full prog");
    repeat (SHUTDOWN_CYC + 20) @(posedge mclk);
    chk(mode_sleep, 1'b0, "sleep ignored");
    chk(array_on, 1'b1, "pdown ignored");
    sector_enable <= 8'hC3;
    cmd(OP_SLEEP);
    repeat (5) @(posedge mclk);
    chk(mode_sleep, 1'b1, "sleep entered");
    chk({array_on, aux_on}, 2'b00, "sleep rails");
    cmd(OP_FETCH);
    rd(REG_STAT);
    chk(q[ST_VALID], 1'b0, "fetch in sleep");
    cmd(OP_STATUS);
    rd(REG_STAT);
    chk(q[ST_VALID], 1'b1, "status in sleep");
    cmd(OP_STANDBY);
    repeat (20) @(posedge mclk);
    chk(sector_on, 8'h00, "sectors during wake");
    repeat (40) @(posedge mclk);
    chk(sector_on, sector_enable, "sectors after wake");
    chk(ready_b, 1'b0, "ready after wake");
    cmd(OP_PDOWN);
    repeat (5) @(posedge mclk);
    chk(ready_b, 1'b1, "shutdown busy");
    repeat (SHUTDOWN_CYC + 10) @(posedge mclk);
    chk(array_on, 1'b0, "powered down");
    pulse();
    wait_rdy();
    chk(n >= PD_WAKE_CYC && n <= PD_WAKE_CYC + 30, 1'b1, "cs wake");
    rd(8'h40);
    chk(err, 1'b1, "unmapped error");
    print_verdict();
  end
endmodule
